// *** aqs_top.sv ***
`timescale 1ns/1ps
`include "aqs_regs.svh"
// Overview of operation
// - first start trigger begins capture, notifies start
// - later slices use next trigger, no notify
// - programmed delay postpones capture after trigger
// - finite frame total limited to fpp times 65534
// - unbounded total runs until channel goes idle
// - high-rate manual stop ends at frame boundary
// - activation arms, first later trigger starts
// - each high-rate phase but the last holds fpp frames
// - finite high-rate sequence stops after last frame
// - report frames done, left and rate
// - line mode splits total into page phases
// - line mode later phases start immediately
// - page 1..65535, total up to page times 65535
// - line mode single sequence, channel self-idles
// - automatic page length unless software sets one
// - start select immediate/hard/soft/combined, default immediate
// - finish completes page, abort at line boundary
// - non-multiple total leaves last page partial
// - frames per phase programmable 1..255
module aqs_top
  import aqs_pkg::*;
#(
  parameter int unsigned RATE_WIN_CYC    = `AQS_RATE_WIN_CYC,
  parameter logic [15:0] AUTO_PAGE_LINES = 16'h0400
) (
  // clock, reset, freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // camera side
  input  wire logic        trig_pin,
  input  wire logic        frame_done,
  input  wire logic        line_done,
  output logic             capture_en,
  output logic             seq_start,
  output logic             slice_start,
  output logic             phase_end,
  output logic             chan_active
);
  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (RATE_WIN_CYC < 1) begin : g_bad_win
    $error("rate window must be at least one cycle");
  end
  if (AUTO_PAGE_LINES == 16'h0000) begin : g_bad_page
    $error("automatic page length must be nonzero");
  end
  ////////////////////////////////////////////////////////////////////////////
  // functions
  // merge bytes under write strobes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction : wmerge
  // trigger source match; combined takes either
  function automatic logic trig_hit(input aqs_start_t s, input logic hw, input logic sw);
    case (s)
      AQS_ST_IMM:  return 1'b1;
      AQS_ST_HARD: return hw;
      AQS_ST_SOFT: return sw;
      AQS_ST_COMB: return hw | sw;
      default:     return 1'b0;
    endcase
  endfunction : trig_hit
  // total is unbounded or within 1..len*mul
  function automatic logic len_ok(input logic [31:0] t, input logic [15:0] len,
                                  input logic [15:0] mul);
    logic [31:0] lim;
    lim = {16'h0000, len} * {16'h0000, mul};
    return (t == `AQS_UNBOUNDED) || ((t != 32'h0) && (len != 16'h0) && (t <= lim));
  endfunction : len_ok
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff; // bus flops
  logic [1:0]  bresp_ff, rresp_ff;       // responses
  logic [31:0] rdata_ff;                 // read data
  logic [7:0]  awaddr_ff;                // held write address
  logic [31:0] wdata_ff;                 // held write data
  logic [3:0]  wstrb_ff;                 // held strobes
  logic        aw_got_ff, w_got_ff;      // halves captured
  logic        run_ff, mode_ff, abort_ff, soft_ff, err_ff; // control bits
  logic [1:0]  ssel_ff;                  // start select
  logic [2:0]  nsel_ff;                  // next select
  logic [31:0] total_ff;                 // sequence total
  logic [7:0]  fpp_ff;                   // frames per phase
  logic [15:0] page_ff;                  // lines per page, 0 = auto
  logic [15:0] dly_ff;                   // trigger delay in us
  logic [2:0]  sync_ff;                  // trigger pin synchroniser
  logic        trig_lvl_ff;              // debounced trigger level
  aqs_state_t  st_ff, nxt_st;            // sequencer state
  aqs_cfg_t    cfg_ff, nxt_cfg;          // frozen parameters
  logic [31:0] done_ff;                  // units acquired
  logic [15:0] inph_ff;                  // units in current phase
  logic [23:0] dlcnt_ff;                 // delay countdown
  logic [31:0] win_ff, winfr_ff, rate_ff;// rate window
  logic        cap_ff, sstart_ff, slice_ff, pend_ff; // output pulses
  logic        aw_take, w_take, wr_fire, ar_take, nxt_aw_got, nxt_w_got, nxt_rvalid;
  logic        wr_ctrl, hw_rise, start_hit, next_hit, unit, bounded;
  logic        last_unit, full, stop_req, cfg_ok, start_go, bad_go;
  logic        seq_begin, fire, ph_end, end_seq;
  logic [15:0] page_eff, plen;
  logic [31:0] left_cnt, rd_mux, ctrl_rd;
  logic        rd_err;
  aqs_start_t  nx_src;
  ////////////////////////////////////////////////////////////////////////////
  // bus handshake terms
  assign aw_take    = awvalid & awready_ff;
  assign w_take     = wvalid & wready_ff;
  assign wr_fire    = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign ar_take    = arvalid & arready_ff;
  assign nxt_aw_got = (aw_got_ff | aw_take) & ~wr_fire;
  assign nxt_w_got  = (w_got_ff | w_take) & ~wr_fire;
  assign nxt_rvalid = ar_take | (rvalid_ff & ~rready);
  assign wr_ctrl    = wr_fire & (awaddr_ff == `AQS_CTRL_OFS);
  // write channels, address and data in either order
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end
    else if (ce)
    begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awready_ff <= ~nxt_aw_got;
      wready_ff  <= ~nxt_w_got;
      if (aw_take) awaddr_ff <= {awaddr[7:2], 2'b00};
      if (w_take)
      begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
    end
  // write response, slverr off the map or onto read-only words
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `AQS_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff <= `AQS_DELAY_OFS) ? `AQS_OKAY : `AQS_SLVERR;
      end
      else if (bready) bvalid_ff <= 1'b0;
    end
  ////////////////////////////////////////////////////////////////////////////
  // software registers
  assign page_eff = (page_ff == 16'h0) ? AUTO_PAGE_LINES : page_ff;
  assign cfg_ok   = mode_ff ? len_ok(total_ff, page_eff, `AQS_CL_PAGES)
                            : len_ok(total_ff, {8'h00, fpp_ff}, `AQS_HR_PHASES);
  assign start_go = (st_ff == AQS_IDLE) & run_ff & cfg_ok;
  assign bad_go   = (st_ff == AQS_IDLE) & run_ff & ~cfg_ok;
  // control word; hardware clears run when the sequence ends
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      run_ff   <= 1'b0;
      mode_ff  <= 1'b0;
      ssel_ff  <= 2'h0;
      nsel_ff  <= 3'h0;
      abort_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl && wstrb_ff[0])
      begin
        run_ff   <= wdata_ff[`AQS_RUN_BIT];
        mode_ff  <= wdata_ff[`AQS_MODE_BIT];
        ssel_ff  <= wdata_ff[`AQS_SSEL_LO +: 2];
        nsel_ff  <= wdata_ff[`AQS_NSEL_LO +: 3];
        abort_ff <= wdata_ff[`AQS_ABORT_BIT];
      end
      else if (end_seq || bad_go) run_ff <= 1'b0;
    end
  // soft trigger pulse and bad-parameter flag
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      soft_ff <= 1'b0;
      err_ff  <= 1'b0;
    end
    else if (ce)
    begin
      soft_ff <= wr_ctrl & wstrb_ff[1] & wdata_ff[`AQS_SOFT_BIT];
      // set wins over the clear of a fresh run write
      if (bad_go) err_ff <= 1'b1;
      else if (wr_ctrl && wstrb_ff[0] && wdata_ff[`AQS_RUN_BIT]) err_ff <= 1'b0;
    end
  // sequence parameters; only a copy is used while running
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      total_ff <= `AQS_TOTAL_RST;
      fpp_ff   <= `AQS_FPP_RST;
      page_ff  <= `AQS_PAGE_RST;
      dly_ff   <= `AQS_DELAY_RST;
    end
    else if (ce && wr_fire)
    begin
      case (awaddr_ff)
        `AQS_TOTAL_OFS: total_ff <= wmerge(total_ff, wdata_ff, wstrb_ff);
        `AQS_FPP_OFS:   fpp_ff   <= 8'(wmerge({24'h0, fpp_ff}, wdata_ff, wstrb_ff));
        `AQS_PAGE_OFS:  page_ff  <= 16'(wmerge({16'h0, page_ff}, wdata_ff, wstrb_ff));
        `AQS_DELAY_OFS: dly_ff   <= 16'(wmerge({16'h0, dly_ff}, wdata_ff, wstrb_ff));
        default: ;
      endcase
    end
  ////////////////////////////////////////////////////////////////////////////
  // trigger pin: three stages, change taken when last two agree
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      sync_ff     <= 3'b000;
      trig_lvl_ff <= 1'b0;
    end
    else if (ce)
    begin
      sync_ff <= {sync_ff[1:0], trig_pin};
      if (sync_ff[1] == sync_ff[2]) trig_lvl_ff <= sync_ff[2];
    end
  assign hw_rise = sync_ff[1] & sync_ff[2] & ~trig_lvl_ff;
  ////////////////////////////////////////////////////////////////////////////
  // sequencer decisions
  always_comb
  begin
    case (cfg_ff.next)
      AQS_NX_SAME: nx_src = cfg_ff.start;
      AQS_NX_HARD: nx_src = AQS_ST_HARD;
      AQS_NX_SOFT: nx_src = AQS_ST_SOFT;
      AQS_NX_COMB: nx_src = AQS_ST_COMB;
      default:     nx_src = AQS_ST_IMM;
    endcase
  end
  assign start_hit = trig_hit(cfg_ff.start, hw_rise, soft_ff);
  assign next_hit  = trig_hit(nx_src, hw_rise, soft_ff);
  assign unit      = (cfg_ff.mode == AQS_CONT_LINE) ? line_done : frame_done;
  assign bounded   = cfg_ff.total != `AQS_UNBOUNDED;
  assign plen      = (cfg_ff.mode == AQS_CONT_LINE) ? cfg_ff.page : {8'h00, cfg_ff.fpp};
  assign last_unit = bounded && ((done_ff + 32'h1) == cfg_ff.total);
  assign full      = (inph_ff + 16'h0001) == plen;
  assign stop_req  = ~run_ff;
  // next state and event strobes
  always_comb
  begin
    nxt_st    = st_ff;
    seq_begin = 1'b0;
    fire      = 1'b0;
    ph_end    = 1'b0;
    end_seq   = 1'b0;
    case (st_ff)
      AQS_IDLE:
        if (start_go) nxt_st = AQS_ARMED;
      AQS_ARMED:
        if (stop_req) nxt_st = AQS_IDLE;
        else if (start_hit)
        begin
          seq_begin = 1'b1;
          fire      = (cfg_ff.dly == 24'h0);
          nxt_st    = fire ? AQS_CAPT : AQS_DELAY;
        end
      AQS_DELAY:
        if (stop_req)
        begin
          nxt_st  = AQS_IDLE;
          ph_end  = inph_ff != 16'h0;
          end_seq = 1'b1;
        end
        else if (dlcnt_ff == 24'h1)
        begin
          fire   = 1'b1;
          nxt_st = AQS_CAPT;
        end
      AQS_CAPT:
        if (unit && cfg_ff.mode == AQS_HIGH_RATE)
        begin
          // a stop is honoured only once the frame is whole
          end_seq = last_unit | stop_req;
          ph_end  = full | end_seq;
          nxt_st  = end_seq ? AQS_IDLE : AQS_WAIT;
        end
        else if (unit)
        begin
          end_seq = last_unit | (stop_req & (cfg_ff.abort | full));
          ph_end  = full | end_seq;
          if (end_seq) nxt_st = AQS_IDLE;
        end
      AQS_WAIT:
        if (stop_req)
        begin
          nxt_st  = AQS_IDLE;
          ph_end  = inph_ff != 16'h0;
          end_seq = 1'b1;
        end
        else if (next_hit)
        begin
          fire   = (cfg_ff.dly == 24'h0);
          nxt_st = fire ? AQS_CAPT : AQS_DELAY;
        end
      default: nxt_st = AQS_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // state and frozen parameters
  always_comb
  begin
    nxt_cfg.mode  = aqs_mode_t'(mode_ff);
    nxt_cfg.start = aqs_start_t'(ssel_ff);
    nxt_cfg.next  = mode_ff ? AQS_NX_REPEAT : aqs_next_t'(nsel_ff);
    nxt_cfg.abort = mode_ff & abort_ff;
    nxt_cfg.total = total_ff;
    nxt_cfg.fpp   = fpp_ff;
    nxt_cfg.page  = page_eff;
    nxt_cfg.dly   = 24'({8'h00, dly_ff} * 24'(`AQS_CYC_PER_US));
  end
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      st_ff  <= AQS_IDLE;
      cfg_ff <= '0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
      if (start_go) cfg_ff <= nxt_cfg;
    end
  // delay countdown
  always_ff @(posedge aclk)
    if (!aresetn) dlcnt_ff <= 24'h0;
    else if (ce)
    begin
      if (nxt_st == AQS_DELAY && st_ff != AQS_DELAY) dlcnt_ff <= cfg_ff.dly;
      else if (st_ff == AQS_DELAY) dlcnt_ff <= dlcnt_ff - 24'h1;
    end
  // progress counters, kept readable after the end
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      done_ff <= 32'h0;
      inph_ff <= 16'h0;
    end
    else if (ce)
    begin
      if (start_go)
      begin
        done_ff <= 32'h0;
        inph_ff <= 16'h0;
      end
      else if (st_ff == AQS_CAPT && unit)
      begin
        done_ff <= done_ff + 32'h1;
        inph_ff <= (full || end_seq) ? 16'h0 : inph_ff + 16'h0001;
      end
      else if (end_seq) inph_ff <= 16'h0;
    end
  // average frame rate over a one-second window
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      win_ff   <= 32'h0;
      winfr_ff <= 32'h0;
      rate_ff  <= 32'h0;
    end
    else if (ce)
    begin
      if (win_ff == RATE_WIN_CYC - 1)
      begin
        win_ff   <= 32'h0;
        winfr_ff <= 32'h0;
        rate_ff  <= (cfg_ff.mode == AQS_HIGH_RATE && cfg_ff.total > 32'h1) ? winfr_ff : 32'h0;
      end
      else
      begin
        win_ff <= win_ff + 32'h1;
        if (st_ff == AQS_CAPT && unit) winfr_ff <= winfr_ff + 32'h1;
      end
    end
  // output pulses and capture gate
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      cap_ff    <= 1'b0;
      sstart_ff <= 1'b0;
      slice_ff  <= 1'b0;
      pend_ff   <= 1'b0;
    end
    else if (ce)
    begin
      cap_ff    <= nxt_st == AQS_CAPT;
      sstart_ff <= seq_begin;
      slice_ff  <= fire;
      pend_ff   <= ph_end;
    end
  ////////////////////////////////////////////////////////////////////////////
  // register read
  assign left_cnt = bounded ? cfg_ff.total - done_ff : 32'h0;
  assign ctrl_rd  = {23'h0, 1'b0, abort_ff, nsel_ff, ssel_ff, mode_ff, run_ff};
  always_comb
  begin
    rd_err = 1'b0;
    case ({araddr[7:2], 2'b00})
      `AQS_CTRL_OFS:  rd_mux = ctrl_rd;
      `AQS_TOTAL_OFS: rd_mux = total_ff;
      `AQS_FPP_OFS:   rd_mux = {24'h0, fpp_ff};
      `AQS_PAGE_OFS:  rd_mux = {16'h0, page_eff};
      `AQS_DELAY_OFS: rd_mux = {16'h0, dly_ff};
      `AQS_STAT_OFS:  rd_mux = {26'h0, err_ff, st_ff, cap_ff, run_ff};
      `AQS_DONE_OFS:  rd_mux = done_ff;
      `AQS_LEFT_OFS:  rd_mux = left_cnt;
      `AQS_RATE_OFS:  rd_mux = rate_ff;
      default:
      begin
        rd_mux = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= `AQS_OKAY;
    end
    else if (ce)
    begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_err ? `AQS_SLVERR : `AQS_OKAY;
      end
    end
  // ports
  assign awready     = awready_ff;
  assign wready      = wready_ff;
  assign bvalid      = bvalid_ff;
  assign bresp       = bresp_ff;
  assign arready     = arready_ff;
  assign rvalid      = rvalid_ff;
  assign rdata       = rdata_ff;
  assign rresp       = rresp_ff;
  assign capture_en  = cap_ff;
  assign seq_start   = sstart_ff;
  assign slice_start = slice_ff;
  assign phase_end   = pend_ff;
  assign chan_active = run_ff;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  sequence armed_trig_s;
    st_ff == AQS_ARMED && !stop_req && start_hit;
  endsequence
  sequence start_pulse_s;
    sstart_ff && done_ff == 32'h0;
  endsequence
  seq_notify_a: assert property (armed_trig_s |=> start_pulse_s)
    else $error("start trigger gave no start notice");
  no_renotify_a: assert property (st_ff == AQS_WAIT |=> !sstart_ff)
    else $error("start notice on a later slice");
  delay_hold_a: assert property ((st_ff == AQS_DELAY && dlcnt_ff > 24'h1 && !stop_req)
                                 |=> !cap_ff && st_ff == AQS_DELAY)
    else $error("capture began before the delay ran out");
  cfg_range_a: assert property (st_ff != AQS_IDLE |-> (cfg_ff.mode == AQS_CONT_LINE
    || cfg_ff.fpp != 8'h0) && cfg_ff.total != 32'h0)
    else $error("sequence running with illegal parameters");
  frame_stop_a: assert property ((st_ff == AQS_CAPT && cfg_ff.mode == AQS_HIGH_RATE
                                  && !unit) |=> st_ff == AQS_CAPT)
    else $error("high-rate capture left mid frame");
  arm_go_a: assert property (start_go |=> st_ff == AQS_ARMED)
    else $error("activation did not arm the trigger");
  arm_a: assert property ((st_ff == AQS_ARMED && !start_hit)
                          |=> !cap_ff && !sstart_ff)
    else $error("capture began without a start trigger");
  auto_stop_a: assert property ((st_ff == AQS_CAPT && unit && last_unit)
                                |=> st_ff == AQS_IDLE && !run_ff && pend_ff)
    else $error("finite sequence did not stop after the last unit");
  left_cnt_a: assert property ((bounded && st_ff != AQS_IDLE)
                               |-> done_ff < cfg_ff.total)
    else $error("units done overran the programmed total");
  line_cont_a: assert property ((st_ff == AQS_CAPT && cfg_ff.mode == AQS_CONT_LINE
                                 && unit && full && !end_seq) |=> cap_ff && pend_ff)
    else $error("line capture paused between pages");
  abort_a: assert property ((st_ff == AQS_CAPT && cfg_ff.mode == AQS_CONT_LINE && unit
                             && stop_req && cfg_ff.abort) |=> st_ff == AQS_IDLE)
    else $error("abort did not stop at the line boundary");
  cfg_hold_a: assert property ((st_ff != AQS_IDLE && $past(st_ff) != AQS_IDLE)
                               |-> $stable(cfg_ff))
    else $error("parameters changed during a sequence");
endmodule : aqs_top

// *** aqs_regs.svh ***
`ifndef AQS_REGS_SVH
`define AQS_REGS_SVH
// register byte offsets
`define AQS_CTRL_OFS   8'h00
`define AQS_TOTAL_OFS  8'h04
`define AQS_FPP_OFS    8'h08
`define AQS_PAGE_OFS   8'h0C
`define AQS_DELAY_OFS  8'h10
`define AQS_STAT_OFS   8'h14
`define AQS_DONE_OFS   8'h18
`define AQS_LEFT_OFS   8'h1C
`define AQS_RATE_OFS   8'h20
// control field positions
`define AQS_RUN_BIT    0
`define AQS_MODE_BIT   1
`define AQS_SSEL_LO    2
`define AQS_NSEL_LO    4
`define AQS_ABORT_BIT  7
`define AQS_SOFT_BIT   8
// reset values
`define AQS_TOTAL_RST  32'hFFFFFFFF
`define AQS_FPP_RST    8'h01
`define AQS_PAGE_RST   16'h0000
`define AQS_DELAY_RST  16'h0000
// codes and limits
`define AQS_UNBOUNDED  32'hFFFFFFFF
`define AQS_HR_PHASES  16'hFFFE
`define AQS_CL_PAGES   16'hFFFF
`define AQS_OKAY       2'b00
`define AQS_SLVERR     2'b10
// timing
`define AQS_CLK_HZ     10000000
`define AQS_US_PER_S   1000000
`define AQS_CYC_PER_US (`AQS_CLK_HZ / `AQS_US_PER_S)
`define AQS_RATE_WIN_S 1
`define AQS_RATE_WIN_CYC (`AQS_RATE_WIN_S * `AQS_CLK_HZ)
`endif

// *** aqs_pkg.sv ***
package aqs_pkg;
  // capture style
  typedef enum logic {AQS_HIGH_RATE = 1'b0, AQS_CONT_LINE = 1'b1} aqs_mode_t;
  // start trigger source
  typedef enum logic [1:0] {
    AQS_ST_IMM = 2'h0, AQS_ST_HARD = 2'h1, AQS_ST_SOFT = 2'h2, AQS_ST_COMB = 2'h3
  } aqs_start_t;
  // next trigger source
  typedef enum logic [2:0] {
    AQS_NX_SAME = 3'h0, AQS_NX_REPEAT = 3'h1, AQS_NX_HARD = 3'h2,
    AQS_NX_SOFT = 3'h3, AQS_NX_COMB = 3'h4
  } aqs_next_t;
  // sequencer states, gray along idle-armed-delay-capture-wait
  typedef enum logic [2:0] {
    AQS_IDLE = 3'b000, AQS_ARMED = 3'b001, AQS_DELAY = 3'b011,
    AQS_CAPT = 3'b010, AQS_WAIT = 3'b110
  } aqs_state_t;
  // parameters frozen at activation
  typedef struct packed {
    aqs_mode_t   mode;
    aqs_start_t  start;
    aqs_next_t   next;
    logic        abort;
    logic [31:0] total;
    logic [7:0]  fpp;
    logic [15:0] page;
    logic [23:0] dly;
  } aqs_cfg_t;
endpackage : aqs_pkg

// *** aqs_cam.sv ***
`timescale 1ns/1ps
// camera model: one unit per capture window step, prompt or slow
module aqs_cam (
  // clock and mode
  input  wire logic aclk,
  input  wire logic line_mode,
  input  wire logic slow,
  // sequencer side
  input  wire logic capture_en,
  // unit completions
  output logic      frame_done,
  output logic      line_done
);
  logic [2:0] cnt_ff; // cycles into the current unit
  logic       hit;    // unit completes this cycle
  //////////////////////////////////////////////////////////////////////
  // count only while capturing, so no unit leaks outside a window
  assign hit = capture_en && (cnt_ff == (slow ? 3'h7 : 3'h2));
  always_ff @(posedge aclk)
  begin
    cnt_ff <= (capture_en && !hit) ? cnt_ff + 3'h1 : 3'h0;
  end
  assign frame_done = hit && !line_mode;
  assign line_done  = hit && line_mode;
endmodule : aqs_cam

// *** tb.sv ***
`timescale 1ns/1ps
`include "aqs_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
  import aqs_pkg::*;
  // bench driven inputs
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, trig_pin = 1'b0, line_mode = 1'b0;
  logic slow = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid, frame_done, line_done;
  logic capture_en, seq_start, slice_start, phase_end, chan_active;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fail_count = 0, checked = 0, n_seq, n_sl, n_ph, t0;
  always #50 aclk = ~aclk;
  aqs_top #(.RATE_WIN_CYC(100)) uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .trig_pin(trig_pin), .frame_done(frame_done),
    .line_done(line_done), .capture_en(capture_en), .seq_start(seq_start),
    .slice_start(slice_start), .phase_end(phase_end), .chan_active(chan_active));
  aqs_cam cam (.aclk(aclk), .line_mode(line_mode), .slow(slow), .capture_en(capture_en),
    .frame_done(frame_done), .line_done(line_done));
  // pulse counters, sampled on the design's own edge
  always @(posedge aclk)
  begin
    n_seq <= n_seq + int'(seq_start);
    n_sl  <= n_sl + int'(slice_start);
    n_ph  <= n_ph + int'(phase_end);
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, dn;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; dn = 1'b0;
    while (!dn)
    begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; dn = bvalid;
      if (dn) `CHK("bresp", r, bresp)
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (dn) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ta, dn;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; dn = 1'b0;
    while (!dn)
    begin
      @(negedge aclk);
      ta = arvalid && arready; dn = rvalid;
      if (dn) `CHK("rdata", e, rdata)
      if (dn) `CHK("rresp", r, rresp)
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (dn) rready <= 1'b0;
    end
  endtask : rd
  // start a run and wait for the channel to drop by itself
  task automatic run(input logic [31:0] c, input int s, input int l, input int p);
    @(negedge aclk);
    n_seq = 0; n_sl = 0; n_ph = 0;
    wr(`AQS_CTRL_OFS, c, `AQS_OKAY);
    for (int i = 0; i < 3000 && chan_active; i++) @(negedge aclk);
    // pulse counters lag the last pulse by one edge
    @(negedge aclk);
    `CHK("active", 1'b0, chan_active)
    `CHK("seq", s, n_seq)
    `CHK("slice", l, n_sl)
    `CHK("phase", p, n_ph)
  endtask : run
  // unbounded soft-started run, stopped by hand at a frame boundary
  task automatic stop_test;
    logic lastf;
    n_seq = 0;
    wr(`AQS_TOTAL_OFS, `AQS_UNBOUNDED, `AQS_OKAY);
    wr(`AQS_DELAY_OFS, 32'h0, `AQS_OKAY);
    wr(`AQS_CTRL_OFS, 32'h19, `AQS_OKAY);
    repeat (10) @(negedge aclk);
    `CHK("soft armed", 0, n_seq)
    wr(`AQS_CTRL_OFS, 32'h119, `AQS_OKAY);
    repeat (300) @(negedge aclk);
    rd(`AQS_LEFT_OFS, 32'h0, `AQS_OKAY);
    `CHK("soft seq", 1, n_seq)
    `CHK("unbounded", 1'b1, chan_active)
    wr(`AQS_CTRL_OFS, 32'h18, `AQS_OKAY);
    lastf = 1'b1;
    @(negedge aclk);
    while (capture_en)
    begin
      lastf = frame_done;
      @(negedge aclk);
    end
    `CHK("whole frame", 1'b1, lastf)
    rd(`AQS_STAT_OFS, 32'h0, `AQS_OKAY);
  endtask : stop_test
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`AQS_TOTAL_OFS, `AQS_TOTAL_RST, `AQS_OKAY);
    rd(`AQS_PAGE_OFS, 32'h400, `AQS_OKAY);
    rd(8'h40, 32'h0, `AQS_SLVERR);
    wr(`AQS_DONE_OFS, 32'h5, `AQS_SLVERR);
    $display("test regs done");
    wr(`AQS_FPP_OFS, 32'h2, `AQS_OKAY);
    wr(`AQS_TOTAL_OFS, 32'h3, `AQS_OKAY);
    run(32'h11, 1, 3, 2);
    rd(`AQS_DONE_OFS, 32'h3, `AQS_OKAY);
    rd(`AQS_LEFT_OFS, 32'h0, `AQS_OKAY);
    $display("test frames done");
    line_mode <= 1'b1;
    slow <= 1'b1;
    wr(`AQS_PAGE_OFS, 32'h3, `AQS_OKAY);
    wr(`AQS_TOTAL_OFS, 32'h7, `AQS_OKAY);
    run(32'h3, 1, 1, 3);
    rd(`AQS_DONE_OFS, 32'h7, `AQS_OKAY);
    $display("test lines done");
    line_mode <= 1'b0;
    wr(`AQS_TOTAL_OFS, 32'h1, `AQS_OKAY);
    wr(`AQS_DELAY_OFS, 32'h2, `AQS_OKAY);
    fork
      run(32'h0D, 1, 1, 1);
      begin
        repeat (30) @(posedge aclk);
        `CHK("armed", 0, n_seq)
        trig_pin <= 1'b1;
        @(posedge seq_start);
        t0 = $time / 100;
        @(posedge capture_en);
        `CHK("delay", 1'b1, ($time / 100 - t0) inside {[20:22]})
        trig_pin <= 1'b0;
      end
    join
    $display("test delay done");
    stop_test();
    $display("test stop done");
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
endmodule : tb
